// *** rtl/pi4_dqpsk_symbol_mapper.sv ***
// Baseband pi/4 DQPSK transmit symbol mapper with pulse shaping and power step lookup
`timescale 1ns/1ps
module pi4_dqpsk_symbol_mapper
  import dqpsk_pkg::*;
#(
  parameter int SYM_CYC = SYM_CYC_DEFAULT
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Chain control
  input wire logic chain_restart,
  // Modulation bits from the burst builder
  input wire logic bit_in,
  input wire logic bit_valid,
  output logic bit_ready,
  // Symbol stream
  output logic sym_strobe,
  output logic [PHASE_W-1:0] sym_phase,
  output logic sym_odd,
  output logic sym_underrun,
  // Shaped baseband to the DAC chain
  output logic signed [OUT_W-1:0] tx_i,
  output logic signed [OUT_W-1:0] tx_q,
  output logic tx_valid,
  // Power control lookup
  input wire logic [STEP_W-1:0] power_step_req,
  input wire logic [PWR_W-1:0] class_limit_hdb,
  output logic [STEP_W-1:0] power_step_grant,
  output logic [PWR_W-1:0] power_hdb,
  output logic power_clamped
);

  localparam int SAMPLE_CYC = SYM_CYC / OSR;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYC - 1);
  // Power of the quietest step, a plain constant so the reset branch stays constant
  localparam logic [PWR_W-1:0] PWR_FLOOR_HDB = PWR_W'(PWR_TOP_HDB - PWR_STEP_HDB * PWR_W'(STEP_MAX - STEP_MIN));

  // Phase step of a bit pair, odd-numbered bit first
  function automatic logic [PHASE_W-1:0] pair_step(input logic odd_b, input logic even_b);
    logic [PHASE_W-1:0] s;
    s = STEP_PLUS1;
    case ({odd_b, even_b})
      2'h3: s = STEP_MINUS3;
      2'h1: s = STEP_PLUS3;
      2'h0: s = STEP_PLUS1;
      default: s = STEP_MINUS1;
    endcase
    return s;
  endfunction

  // Cosine of a pi/4 phase index; the sine uses the same table shifted a quarter turn
  function automatic logic signed [SAMP_W-1:0] cos_lut(input logic [PHASE_W-1:0] idx);
    logic signed [SAMP_W-1:0] v;
    v = AMP_ZERO;
    case (idx)
      3'h0: v = AMP_FULL;
      3'h1: v = AMP_DIAG;
      3'h2: v = AMP_ZERO;
      3'h3: v = -AMP_DIAG;
      3'h4: v = -AMP_FULL;
      3'h5: v = -AMP_DIAG;
      3'h6: v = AMP_ZERO;
      default: v = AMP_DIAG;
    endcase
    return v;
  endfunction

  // Nominal power of a step in half-dBm, 5 dB per step below the top level
  function automatic logic [PWR_W-1:0] step_power(input logic [STEP_W-1:0] s);
    logic [PWR_W-1:0] d;
    d = PWR_W'(s - STEP_MIN);
    return PWR_W'(PWR_TOP_HDB - PWR_W'(d * PWR_STEP_HDB));
  endfunction

  // Highest power at or below the request that the class allows
  function automatic logic [STEP_W-1:0] grant_step(input logic [STEP_W-1:0] req,
                                                   input logic [PWR_W-1:0] limit);
    logic [STEP_W-1:0] g;
    logic found;
    g = STEP_MAX;
    found = 1'b0;
    for (int i = 1; i <= int'(STEP_MAX); i++) begin
      if (!found && STEP_W'(i) >= req && step_power(STEP_W'(i)) <= limit) begin
        g = STEP_W'(i);
        found = 1'b1;
      end
    end
    return g;
  endfunction

  pair_state_type state_r, state_nxt;
  logic [CNT_W-1:0] samp_cnt_r;
  logic [OSR_W-1:0] osr_r;
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic odd_bit_r;
  logic even_bit_r;
  logic sym_strobe_r;
  logic sym_odd_r;
  logic underrun_r;
  logic tick_r;
  logic signed [SAMP_W-1:0] imp_i_r, imp_q_r;
  logic [STEP_W-1:0] grant_r;
  logic [PWR_W-1:0] power_r;
  logic clamped_r;

  wire sample_tick;
  wire sym_instant;
  wire bit_slot;
  wire bit_take;
  wire emit_ref;
  wire emit_pair;
  wire [PHASE_W-1:0] emit_phase;
  wire [STEP_W-1:0] req_legal;
  wire [STEP_W-1:0] grant_nxt;
  wire clamp_nxt;

  shaper_if sif();

  // Sample pacing: OSR samples per symbol, symbol instant at slot zero
  assign sample_tick = (samp_cnt_r == SAMPLE_LAST);
  assign sym_instant = sample_tick && (osr_r == OSR_SYM_SLOT);
  // Bit slots sit between symbol instants, two per symbol period
  assign bit_slot = sample_tick && osr_r[0];
  assign bit_ready = bit_slot && ((state_r == ST_ODD) || (state_r == ST_EVEN));
  assign bit_take = bit_ready && bit_valid;

  // Symbol decisions at each symbol instant
  assign emit_ref = sym_instant && (state_r == ST_REF);
  assign emit_pair = sym_instant && (state_r == ST_FULL);
  assign phase_nxt = phase_r + pair_step(odd_bit_r, even_bit_r);
  assign emit_phase = emit_pair ? phase_nxt : phase_r;

  // Sample counter, free running so the symbol grid never slips
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      samp_cnt_r <= '0;
      osr_r <= OSR_SYM_SLOT;
    end else if (sample_tick) begin
      samp_cnt_r <= '0;
      osr_r <= (osr_r == OSR_LAST) ? OSR_SYM_SLOT : osr_r + 2'h1;
    end else begin
      samp_cnt_r <= samp_cnt_r + 13'h0001;
    end
  end

  // Pairing state: odd bit, even bit, then a full pair waits for its symbol instant
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_REF: begin
        if (sym_instant) begin
          state_nxt = ST_ODD;
        end
      end
      ST_ODD: begin
        if (bit_take) begin
          state_nxt = ST_EVEN;
        end
      end
      ST_EVEN: begin
        if (bit_take) begin
          state_nxt = ST_FULL;
        end
      end
      ST_FULL: begin
        if (sym_instant) begin
          state_nxt = ST_ODD;
        end
      end
      default: state_nxt = ST_REF;
    endcase
    if (chain_restart) begin
      state_nxt = ST_REF;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_REF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit capture; the odd bit holds across a missed symbol instant
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      odd_bit_r <= 1'b0;
      even_bit_r <= 1'b0;
    end else if (bit_take && state_r == ST_ODD) begin
      odd_bit_r <= bit_in;
    end else if (bit_take && state_r == ST_EVEN) begin
      even_bit_r <= bit_in;
    end
  end

  // Phase state survives bursts; only reset or an explicit restart returns it to zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PHASE_REF;
    end else if (chain_restart) begin
      phase_r <= PHASE_REF;
    end else if (emit_pair) begin
      phase_r <= phase_nxt;
    end
  end

  // Symbol parity: reference is k=0, each pair flips between even and odd phase sets
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sym_odd_r <= 1'b0;
    end else if (chain_restart || emit_ref) begin
      sym_odd_r <= 1'b0;
    end else if (emit_pair) begin
      sym_odd_r <= ~sym_odd_r;
    end
  end

  // Symbol strobe and underrun; a late pair costs a silent symbol slot, not a phase error
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sym_strobe_r <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      sym_strobe_r <= emit_ref || emit_pair;
      underrun_r <= sym_instant && (state_r == ST_ODD || state_r == ST_EVEN);
    end
  end

  // Impulse to the filter: the symbol at its instant, zero on every other sample
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      imp_i_r <= AMP_ZERO;
      imp_q_r <= AMP_ZERO;
      tick_r <= 1'b0;
    end else begin
      tick_r <= sample_tick;
      if (emit_ref || emit_pair) begin
        imp_i_r <= cos_lut(emit_phase);
        imp_q_r <= cos_lut(emit_phase - PHASE_QUARTER);
      end else if (sample_tick) begin
        imp_i_r <= AMP_ZERO;
        imp_q_r <= AMP_ZERO;
      end
    end
  end

  // Registered tick lines up with the impulse registers above
  assign sif.sample_tick = tick_r;
  assign sif.impulse_i = imp_i_r;
  assign sif.impulse_q = imp_q_r;

  // Shaping filter; 17 taps trade stopband depth for area
  rrc_shaper u_shaper (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sif(sif.shaper)
  );

  // Power step lookup; an out-of-range request falls to the quietest step, STEP_MAX
  assign req_legal = (power_step_req < STEP_MIN) ? STEP_MAX : power_step_req;
  assign grant_nxt = grant_step(req_legal, class_limit_hdb);
  // Flag a changed step, and also a floor step that still sits above the class limit
  assign clamp_nxt = (grant_nxt != req_legal) || (step_power(grant_nxt) > class_limit_hdb);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      grant_r <= STEP_MAX;
      power_r <= PWR_FLOOR_HDB;
      clamped_r <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      power_r <= step_power(grant_nxt);
      clamped_r <= clamp_nxt;
    end
  end

  // Outputs
  assign sym_strobe = sym_strobe_r;
  assign sym_phase = phase_r;
  assign sym_odd = sym_odd_r;
  assign sym_underrun = underrun_r;
  assign tx_i = sif.out_i;
  assign tx_q = sif.out_q;
  assign tx_valid = sif.out_valid;
  assign power_step_grant = grant_r;
  assign power_hdb = power_r;
  assign power_clamped = clamped_r;

endmodule

// *** common/dqpsk_pkg.sv ***
// Shared constants and types for the pi/4 DQPSK symbol mapper and its shaping filter
package dqpsk_pkg;

  // Clock and line rate
  localparam int CLK_HZ = 125_000_000;
  localparam int BIT_RATE_BPS = 36_000;
  localparam int BITS_PER_SYM = 2;
  // Symbol period in clock cycles, rounded down (6944)
  localparam int SYM_CYC_DEFAULT = (CLK_HZ * BITS_PER_SYM) / BIT_RATE_BPS;

  // Oversampling of the shaping filter and its span
  localparam int OSR = 4;
  localparam int OSR_W = 2;
  localparam logic [OSR_W-1:0] OSR_SYM_SLOT = 2'h0;
  localparam logic [OSR_W-1:0] OSR_LAST = 2'h3;
  localparam int NTAPS = 17;
  localparam int CNT_W = 13;

  // Sample and coefficient widths
  localparam int SAMP_W = 10;
  localparam int COEF_W = 10;
  localparam int PROD_W = SAMP_W + COEF_W;
  localparam int ACC_W = 25;
  localparam int OUT_W = 16;
  localparam int OUT_LSB = 5;

  // Constellation amplitudes: unit circle and its 45 degree projection
  localparam logic signed [SAMP_W-1:0] AMP_FULL = 10'h0FF;
  localparam logic signed [SAMP_W-1:0] AMP_DIAG = 10'h0B4;
  localparam logic signed [SAMP_W-1:0] AMP_ZERO = 10'h000;

  // Phase index in units of pi/4 and the four transitions
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_REF = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_QUARTER = 3'h2;
  localparam logic [PHASE_W-1:0] STEP_PLUS1 = 3'h1;
  localparam logic [PHASE_W-1:0] STEP_PLUS3 = 3'h3;
  localparam logic [PHASE_W-1:0] STEP_MINUS3 = 3'h5;
  localparam logic [PHASE_W-1:0] STEP_MINUS1 = 3'h7;

  // Windowed root raised cosine, roll-off 0.35, four symbols span, OSR 4
  localparam logic signed [COEF_W-1:0] RRC_COEF [NTAPS] = '{
    10'h00D, 10'h3F6, 10'h3C1, 10'h3A8, 10'h3D8, 10'h060, 10'h11B, 10'h1BF, 10'h1FF,
    10'h1BF, 10'h11B, 10'h060, 10'h3D8, 10'h3A8, 10'h3C1, 10'h3F6, 10'h00D};

  // Power control steps, powers in half-dBm units
  localparam int STEP_W = 3;
  localparam int PWR_W = 7;
  localparam logic [STEP_W-1:0] STEP_MIN = 3'h1;
  localparam logic [STEP_W-1:0] STEP_MAX = 3'h7;
  localparam logic [PWR_W-1:0] PWR_TOP_HDB = 7'h5A;
  localparam logic [PWR_W-1:0] PWR_STEP_HDB = 7'h0A;

  // Bit pairing state
  typedef enum logic [3:0] {
    ST_REF = 4'h1,
    ST_ODD = 4'h2,
    ST_EVEN = 4'h4,
    ST_FULL = 4'h8
  } pair_state_type;

endpackage

// *** common/shaper_if.sv ***
// Carrier between the symbol mapper and the shaping filter
`timescale 1ns/1ps
interface shaper_if;
  import dqpsk_pkg::*;
  logic sample_tick;
  logic signed [SAMP_W-1:0] impulse_i;
  logic signed [SAMP_W-1:0] impulse_q;
  logic signed [OUT_W-1:0] out_i;
  logic signed [OUT_W-1:0] out_q;
  logic out_valid;

  modport mapper (output sample_tick, output impulse_i, output impulse_q,
                  input out_i, input out_q, input out_valid);
  modport shaper (input sample_tick, input impulse_i, input impulse_q,
                  output out_i, output out_q, output out_valid);
endinterface

// *** rtl/rrc_shaper.sv ***
// Oversampled root raised cosine FIR for both I and Q rails
`timescale 1ns/1ps
module rrc_shaper
  import dqpsk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Impulse stream in, shaped samples out
  shaper_if.shaper sif
);

  logic signed [SAMP_W-1:0] line_r [2][NTAPS];
  logic signed [ACC_W-1:0] acc [2];
  logic signed [OUT_W-1:0] out_r [2];
  logic signed [SAMP_W-1:0] rail_in [2];
  logic valid_r;

  // Rail inputs
  assign rail_in[0] = sif.impulse_i;
  assign rail_in[1] = sif.impulse_q;

  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_rail
      // Delay line: one complex sample per tick, symbols arrive as lone impulses
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          for (int t = 0; t < NTAPS; t++) begin
            line_r[r][t] <= AMP_ZERO;
          end
        end else if (sif.sample_tick) begin
          line_r[r][0] <= rail_in[r];
          for (int t = 1; t < NTAPS; t++) begin
            line_r[r][t] <= line_r[r][t-1];
          end
        end
      end

      // Sum of shifted pulses; symmetric taps keep the phase linear
      always_comb begin
        logic signed [ACC_W-1:0] sum_v;
        logic signed [PROD_W-1:0] prod_v;
        sum_v = '0;
        prod_v = '0;
        for (int t = 0; t < NTAPS; t++) begin
          prod_v = line_r[r][t] * RRC_COEF[t];
          sum_v = sum_v + ACC_W'(prod_v);
        end
        acc[r] = sum_v;
      end

      // Output scaling; the dropped top bits never carry for unit-amplitude symbols
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          out_r[r] <= '0;
        end else if (sif.sample_tick) begin
          out_r[r] <= acc[r][OUT_LSB +: OUT_W];
        end
      end
    end
  endgenerate

  // One-cycle marker that a new shaped sample stands on the outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= sif.sample_tick;
    end
  end

  assign sif.out_i = out_r[0];
  assign sif.out_q = out_r[1];
  assign sif.out_valid = valid_r;

endmodule

// *** dv/mapper_properties.sv ***
// Port-level checks for the pi/4 DQPSK symbol mapper
`timescale 1ns/1ps
module mapper_properties
  import dqpsk_pkg::*;
#(
  parameter int SYM_CYC = 32
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports
  input wire logic chain_restart,
  input wire logic bit_ready,
  input wire logic sym_strobe,
  input wire logic [PHASE_W-1:0] sym_phase,
  input wire logic sym_odd,
  input wire logic sym_underrun,
  input wire logic tx_valid,
  input wire logic [STEP_W-1:0] power_step_req,
  input wire logic [PWR_W-1:0] class_limit_hdb,
  input wire logic [STEP_W-1:0] power_step_grant,
  input wire logic [PWR_W-1:0] power_hdb,
  input wire logic power_clamped
);
  localparam int SAMP = SYM_CYC / 4;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Short quiet stretches; the smallest legal SYM_CYC still leaves eight idle cycles
  sequence no_strobe;
    !sym_strobe [*8];
  endsequence
  sequence no_ready;
    !bit_ready [*8];
  endsequence

  a_strobe_spacing: assert property (sym_strobe |=> no_strobe)
    else $error("symbol strobes too close");
  a_ready_spacing: assert property (bit_ready |=> no_ready)
    else $error("bit slots too close");
  a_sample_rate: assert property (tx_valid |-> ##SAMP tx_valid)
    else $error("shaped sample late");
  a_phase_parity: assert property (sym_strobe |-> sym_phase[0] == sym_odd)
    else $error("phase subset wrong for symbol parity");
  a_phase_hold: assert property (!sym_strobe && !$past(chain_restart) |-> $stable(sym_phase))
    else $error("phase moved without a symbol");
  a_underrun_hold: assert property (sym_underrun |-> !sym_strobe && $stable(sym_phase))
    else $error("phase moved on an underrun");
  a_power_table: assert property (power_hdb == 7'(PWR_TOP_HDB - PWR_STEP_HDB * (power_step_grant - 3'h1)))
    else $error("power does not match step");
  a_class_limit: assert property ($past(reset_n) && !power_clamped |-> power_hdb <= $past(class_limit_hdb))
    else $error("granted power above class limit");
  a_grant_floor: assert property ($past(reset_n) |->
    power_step_grant >= (($past(power_step_req) == 3'h0) ? STEP_MAX : $past(power_step_req)))
    else $error("grant louder than request");
endmodule

bind pi4_dqpsk_symbol_mapper mapper_properties #(.SYM_CYC(SYM_CYC)) i_mapper_properties (.clk_sys, .reset_n,
  .chain_restart, .bit_ready, .sym_strobe, .sym_phase, .sym_odd, .sym_underrun, .tx_valid, .power_step_req,
  .class_limit_hdb, .power_step_grant, .power_hdb, .power_clamped);

// *** dv/bit_source.sv ***
// Burst builder stand-in: queues modulation bits and offers them on the bit handshake
`timescale 1ns/1ps
module bit_source (
  // Clock
  input wire logic clk_sys,
  // Bit handshake
  input wire logic bit_ready,
  output logic bit_in,
  output logic bit_valid
);
  logic q[$];
  logic last_bit = 1'b0;

  // Bits go in transmit order, odd bit of each pair first
  task automatic push(input logic b);
    q.push_back(b);
  endtask

  // Pop only on an accepted bit so a refused bit is offered again
  always @(posedge clk_sys) begin
    if (bit_valid && bit_ready && q.size() > 0) begin
      last_bit = q.pop_front();
    end
  end

  // Idle line shows the inverted last bit so a stale value cannot pass for data
  always @(negedge clk_sys) begin
    bit_valid <= (q.size() > 0);
    bit_in <= (q.size() > 0) ? q[0] : !last_bit;
  end
endmodule

// *** dv/test_pi4_dqpsk_symbol_mapper.sv ***
// Self-checking bench for the pi/4 DQPSK symbol mapper
`timescale 1ns/1ps
module test_pi4_dqpsk_symbol_mapper
  import dqpsk_pkg::*;
;
  localparam int SYM = 32;
  // Pulse selectors for the bounded wait
  localparam int SEL_STROBE = 0;
  localparam int SEL_UNDERRUN = 1;
  localparam int SEL_VALID = 2;
  logic clk_sys, reset_n, chain_restart, bit_in, bit_valid, bit_ready;
  logic sym_strobe, sym_odd, sym_underrun, tx_valid, power_clamped;
  logic [PHASE_W-1:0] sym_phase, exp_phase;
  logic signed [OUT_W-1:0] tx_i, tx_q;
  logic [STEP_W-1:0] power_step_req, power_step_grant;
  logic [PWR_W-1:0] class_limit_hdb, power_hdb;
  int err_total = 0;
  int tests_run = 0;

  // Short symbol period keeps the run brief
  pi4_dqpsk_symbol_mapper #(.SYM_CYC(SYM)) i_pi4_dqpsk_symbol_mapper (.clk_sys, .reset_n, .chain_restart,
    .bit_in, .bit_valid, .bit_ready, .sym_strobe, .sym_phase, .sym_odd, .sym_underrun, .tx_i, .tx_q,
    .tx_valid, .power_step_req, .class_limit_hdb, .power_step_grant, .power_hdb, .power_clamped);
  bit_source i_bit_source (.clk_sys, .bit_ready, .bit_in, .bit_valid);

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Bounded wait for a one-cycle pulse, looked at after the edge settles
  task automatic wait_for(input int sel, input string what);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      s = (sel == SEL_STROBE) ? sym_strobe : (sel == SEL_UNDERRUN) ? sym_underrun : tx_valid;
    end while (s !== 1'b1 && n < 4 * SYM);
    check(what, 1, s);
  endtask

  function automatic int pw(input int s);
    return 90 - 10 * (s - 1);
  endfunction

  task automatic t_reference();
    wait_for(SEL_STROBE, "reference strobe");
    check("reference phase", 0, sym_phase);
    check("reference parity", 0, sym_odd);
    exp_phase = PHASE_REF;
    $display("test reference done");
  endtask

  task automatic t_pairs();
    logic [1:0] pairs [7] = '{2'b11, 2'b01, 2'b00, 2'b10, 2'b01, 2'b01, 2'b00};
    logic [PHASE_W-1:0] steps [4] = '{STEP_PLUS1, STEP_PLUS3, STEP_MINUS1, STEP_MINUS3};
    time t0;
    foreach (pairs[i]) begin
      i_bit_source.push(pairs[i][1]);
      i_bit_source.push(pairs[i][0]);
    end
    foreach (pairs[i]) begin
      wait_for(SEL_STROBE, "pair strobe");
      if (i > 0) check("symbol spacing", 16'(SYM * 8), 16'($time - t0));
      t0 = $time;
      exp_phase = exp_phase + steps[pairs[i]];
      check("pair phase", exp_phase, sym_phase);
      check("pair parity", i % 2 == 0, sym_odd);
    end
    $display("test pairs done");
  endtask

  // Starved stream: phase must wait, then resume from where it stood
  task automatic t_underrun();
    wait_for(SEL_UNDERRUN, "underrun flag");
    check("phase kept", exp_phase, sym_phase);
    i_bit_source.push(1'b1);
    i_bit_source.push(1'b0);
    wait_for(SEL_STROBE, "strobe after gap");
    exp_phase = exp_phase + STEP_MINUS1;
    check("phase after gap", exp_phase, sym_phase);
    check("parity after gap", 0, sym_odd);
    $display("test underrun done");
  endtask

  // Lone reference impulse: pulse must be symmetric, peak exact, tails empty
  task automatic t_shape();
    logic signed [OUT_W-1:0] v [26];
    repeat (6 * SYM) @(posedge clk_sys);
    @(negedge clk_sys);
    chain_restart = 1'b1;
    @(negedge clk_sys);
    chain_restart = 1'b0;
    wait_for(SEL_STROBE, "restart strobe");
    check("restart phase", 0, sym_phase);
    for (int s = 0; s < 26; s++) begin
      wait_for(SEL_VALID, "sample strobe");
      v[s] = tx_i;
      check("quadrature rail", 0, tx_q);
    end
    check("pulse peak", 16'((int'(AMP_FULL) * int'(RRC_COEF[8])) >>> OUT_LSB), v[9]);
    for (int d = 1; d < 10; d++) begin
      check("pulse symmetry", v[9 - d], v[9 + d]);
    end
    check("pulse tail", 0, v[18]);
    $display("test shape done");
  endtask

  task automatic t_power();
    logic [PWR_W-1:0] lims [4] = '{7'h5A, 7'h55, 7'h1E, 7'h14};
    logic [STEP_W-1:0] lg, g;
    foreach (lims[j]) begin
      for (int r = 0; r < 8; r++) begin
        @(negedge clk_sys);
        power_step_req = 3'(r);
        class_limit_hdb = lims[j];
        lg = (r == 0) ? STEP_MAX : 3'(r);
        g = lg;
        while (g < STEP_MAX && pw(g) > lims[j]) g++;
        @(posedge clk_sys);
        #1;
        check("granted step", g, power_step_grant);
        check("step power", pw(g), power_hdb);
        check("clamp flag", g != lg || pw(g) > lims[j], power_clamped);
      end
    end
    $display("test power done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    chain_restart = 1'b0;
    power_step_req = 3'h1;
    class_limit_hdb = 7'h5A;
    repeat (2) @(negedge clk_sys);
    check("reset grant", STEP_MAX, power_step_grant);
    check("reset phase", PHASE_REF, sym_phase);
    reset_n = 1'b1;
    t_reference();
    t_pairs();
    t_underrun();
    t_shape();
    t_power();
    give_verdict();
  end

  // Watchdog, about two and a half times the expected run
  initial begin
    #(SYM * 8 * 60);
    err_total++;
    $display("FAIL watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule
